// ### rtl/master_clock_select_config.v
// global clock select and receive config register with ahb-lite slave
// assumes single-word ahb-lite transfers; rx pins come from outside clock domain
//
// Contract
// - register splits into upper 7:3, lower 2:0
// - bit 7 picks violation or overflow output
// - bits 6:4 choose synthesizer reference frequency
// - bit 3 picks e1 or t1 rate
// - bit 2 squelches rx data on loss
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "clock_select_map.vh"
module master_clock_select_config
#(
   parameter CHANNELS = 8
)
(
   // clock and reset
   input  wire                clock,
   input  wire                reset_n,
   // ahb-lite slave
   input  wire                hsel,
   input  wire [11:0]         haddr,
   input  wire [1:0]          htrans,
   input  wire                hwrite,
   input  wire [2:0]          hsize,
   input  wire [31:0]         hwdata,
   input  wire                hready,
   output reg  [31:0]         hrdata,
   output reg                 hreadyout,
   output reg                 hresp,
   // interrupt
   output reg                 irq,
   // per channel receive side, from pins
   input  wire [CHANNELS-1:0] rx_signal_loss,
   input  wire [CHANNELS-1:0] rx_pos_in,
   input  wire [CHANNELS-1:0] rx_neg_in,
   input  wire [CHANNELS-1:0] code_violation_in,
   input  wire [CHANNELS-1:0] counter_overflow_in,
   output wire [CHANNELS-1:0] rx_positive_out,
   output wire [CHANNELS-1:0] rx_negative_out,
   output reg  [CHANNELS-1:0] violation_event_output,
   // synthesizer control
   output reg  [2:0]          synth_ref_select,
   output reg                 master_rate_select,
   output reg                 synth_retuning,
   output reg                 extended_loss_window,
   output reg                 board_test_tristate
);
   // settle window in whole clock cycles, rounded up
   localparam integer RETUNE_CALC   = (`RETUNE_NS * `CLOCK_MHZ + 999) / 1000;
   localparam [3:0]   RETUNE_CYCLES = RETUNE_CALC[3:0];

   // two-flop synchronisers for pin inputs
   reg [CHANNELS-1:0] los_m_q, los_q, pos_m_q, pos_q, neg_m_q, neg_q;
   reg [CHANNELS-1:0] cv_m_q, cv_q, of_m_q, of_q;

   // ahb state
   reg        wr_pend_q, rd_pend_q;
   reg [11:0] addr_q;

   reg [7:0]  cfg_q;
   reg [`IRQ_WIDTH-1:0] irq_stat_q, irq_mask_q;
   reg [3:0]  retune_cnt_q;
   reg        apply_q;
   reg [31:0] rd_word;

   wire       take = hsel && hready && htrans[1];
   wire [7:0] wbyte = hwdata[7:0];
   wire       cfg_wr = wr_pend_q && (addr_q == `CFG_ADDR);
   wire [7:0] diff = wbyte ^ cfg_q;
   // each group compared against the stored byte
   wire       upper_chg = |diff[`UPPER_HI:`UPPER_LO];
   wire       lower_chg = |diff[`LOWER_HI:0];
   wire       synth_chg = |diff[`F_REF_HI:`F_RATE];
   // both groups in one write: still applied, but flagged
   wire       split_err = cfg_wr && upper_chg && lower_chg;
   // done on the last count of the window
   wire       retune_done = (retune_cnt_q == 4'd1);
   wire [`IRQ_WIDTH-1:0] irq_set;

   // sticky status sources
   assign irq_set[`IRQ_RETUNE_DONE] = retune_done;
   assign irq_set[`IRQ_SPLIT_ERR]   = split_err;

   // register read mux, looked up in the address phase
   always @*
   begin
      rd_word = 32'h0000_0000;
      case (haddr)
         `CFG_ADDR:        rd_word = {24'h00_0000, cfg_q};
         `IRQ_STATUS_ADDR: rd_word = {{(32-`IRQ_WIDTH){1'b0}}, irq_stat_q};
         `IRQ_MASK_ADDR:   rd_word = {{(32-`IRQ_WIDTH){1'b0}}, irq_mask_q};
         default:          rd_word = 32'h0000_0000;
      endcase
   end

   always @(posedge clock)
   begin
      los_m_q <= rx_signal_loss;
      los_q   <= los_m_q;
      pos_m_q <= rx_pos_in;
      pos_q   <= pos_m_q;
      neg_m_q <= rx_neg_in;
      neg_q   <= neg_m_q;
      cv_m_q  <= code_violation_in;
      cv_q    <= cv_m_q;
      of_m_q  <= counter_overflow_in;
      of_q    <= of_m_q;
   end

   // bus slave and registers
   always @(posedge clock)
   begin
      if (!reset_n)
      begin
         wr_pend_q  <= 1'b0;
         rd_pend_q  <= 1'b0;
         addr_q     <= 12'h000;
         hrdata     <= 32'h0000_0000;
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
         cfg_q      <= `CFG_RESET;
         irq_stat_q <= {`IRQ_WIDTH{1'b0}};
         irq_mask_q <= {`IRQ_WIDTH{1'b0}};
         irq        <= 1'b0;
      end
      else
      begin
         hresp     <= 1'b0;
         hreadyout <= 1'b1;
         wr_pend_q <= take && hwrite;
         rd_pend_q <= take && !hwrite;
         if (take)
            addr_q <= haddr;
         // hold read data for the data phase
         if (take && !hwrite)
            hrdata <= rd_word;
         // clear it once that phase is over
         else if (rd_pend_q)
            hrdata <= 32'h0000_0000;
         // either sub-field alone, in any order, is accepted in one write
         if (cfg_wr)
            cfg_q <= wbyte;
         if (wr_pend_q && (addr_q == `IRQ_MASK_ADDR))
            irq_mask_q <= hwdata[`IRQ_WIDTH-1:0];
         // set wins over write-one-to-clear
         if (wr_pend_q && (addr_q == `IRQ_STATUS_ADDR))
            irq_stat_q <= (irq_stat_q & ~hwdata[`IRQ_WIDTH-1:0]) | irq_set;
         else
            irq_stat_q <= irq_stat_q | irq_set;
         // level interrupt lags status by one cycle
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end

   // apply register to outputs after the write, with retune window
   always @(posedge clock)
   begin
      if (!reset_n)
      begin
         apply_q              <= 1'b0;
         retune_cnt_q         <= 4'd0;
         synth_ref_select     <= 3'b000;
         master_rate_select   <= 1'b0;
         synth_retuning       <= 1'b0;
         extended_loss_window <= 1'b0;
         board_test_tristate  <= 1'b0;
      end
      else
      begin
         // retune only when rate or reference bits move
         apply_q <= cfg_wr && synth_chg;
         if (apply_q)
            retune_cnt_q <= RETUNE_CYCLES;
         else if (retune_cnt_q != 4'd0)
            retune_cnt_q <= retune_cnt_q - 4'd1;
         synth_retuning       <= apply_q || (retune_cnt_q > 4'd1);
         // outputs follow the stored byte one cycle later
         synth_ref_select     <= cfg_q[`F_REF_HI:`F_REF_LO];
         master_rate_select   <= cfg_q[`F_RATE];
         extended_loss_window <= cfg_q[`F_EXT_LOSS];
         board_test_tristate  <= cfg_q[`F_TEST_TRI];
      end
   end

   // shared violation output
   always @(posedge clock)
   begin
      if (!reset_n)
         violation_event_output <= {CHANNELS{1'b0}};
      else if (cfg_q[`F_OVF_SEL])
         violation_event_output <= of_q;
      else
         violation_event_output <= cv_q;
   end

   // one squelch lane per receive channel
   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch = ch + 1)
      begin : lane
         rx_squelch_lane u_lane
         (
            .clock           (clock),
            .reset_n         (reset_n),
            .squelch_en      (cfg_q[`F_SQUELCH]),
            .rx_signal_loss  (los_q[ch]),
            .rx_pos_in       (pos_q[ch]),
            .rx_neg_in       (neg_q[ch]),
            .rx_positive_out (rx_positive_out[ch]),
            .rx_negative_out (rx_negative_out[ch])
         );
      end
   endgenerate
endmodule
`default_nettype wire

// ### rtl/clock_select_map.vh
// register map and field positions for the global clock select block
// assumes inclusion by bare name from rtl design files
`ifndef CLOCK_SELECT_MAP_VH
`define CLOCK_SELECT_MAP_VH

// byte addresses: printed offset 0x81 is not a multiple of four, so index*4
`define CFG_INDEX        8'h81
`define CFG_ADDR         12'h0204
`define IRQ_STATUS_ADDR  12'h0208
`define IRQ_MASK_ADDR    12'h020C
`define CFG_RESET        8'h00

// field positions
`define F_OVF_SEL        7
`define F_REF_HI         6
`define F_REF_LO         4
`define F_RATE           3
`define F_SQUELCH        2
`define F_EXT_LOSS       1
`define F_TEST_TRI       0
`define UPPER_HI         7
`define UPPER_LO         3
`define LOWER_HI         2

// interrupt status bits
`define IRQ_RETUNE_DONE  0
`define IRQ_SPLIT_ERR    1
`define IRQ_WIDTH        2

// retune settle time
`define RETUNE_NS        40
`define CLOCK_MHZ        250

`endif

// ### rtl/rx_squelch_lane.v
// one channel of receive data squelching on loss of signal
// assumes loss input already synchronised to clock
`timescale 1ns/1ps
`default_nettype none
module rx_squelch_lane
(
   // clock and reset
   input  wire clock,
   input  wire reset_n,
   // control
   input  wire squelch_en,
   input  wire rx_signal_loss,
   // data
   input  wire rx_pos_in,
   input  wire rx_neg_in,
   output reg  rx_positive_out,
   output reg  rx_negative_out
);
   always @(posedge clock)
   begin
      if (!reset_n)
      begin
         rx_positive_out <= 1'b0;
         rx_negative_out <= 1'b0;
      end
      else if (squelch_en && rx_signal_loss)
      begin
         rx_positive_out <= 1'b0;
         rx_negative_out <= 1'b0;
      end
      else
      begin
         rx_positive_out <= rx_pos_in;
         rx_negative_out <= rx_neg_in;
      end
   end
endmodule
`default_nettype wire

// ### test/mcs_chk.sv
// assertions on the clock select block ports
// bound into the design top, ports by name
`timescale 1ns/1ps
`default_nettype none
module mcs_chk #(parameter CHANNELS = 8)
(
   // bus
   input wire                clock,
   input wire                reset_n,
   input wire [11:0]         haddr,
   input wire [1:0]          htrans,
   input wire                hwrite,
   input wire [31:0]         hwdata,
   // receive side
   input wire [CHANNELS-1:0] rx_signal_loss,
   input wire [CHANNELS-1:0] code_violation_in,
   input wire [CHANNELS-1:0] counter_overflow_in,
   input wire [CHANNELS-1:0] rx_positive_out,
   input wire [CHANNELS-1:0] violation_event_output,
   // synthesizer
   input wire [2:0]          synth_ref_select,
   input wire                master_rate_select,
   input wire                synth_retuning,
   input wire                extended_loss_window
);
   logic       wa_q;
   logic [7:0] cfg_q;
   always @(posedge clock)
   begin
      wa_q <= reset_n && htrans[1] && hwrite && haddr == 12'h204;
      cfg_q <= !reset_n ? 8'h00 : wa_q ? hwdata[7:0] : cfg_q;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   ref_track_a: assert property (wa_q |-> ##3 synth_ref_select == cfg_q[6:4])
      else $error("ref select");
   rate_track_a: assert property (wa_q |-> ##3 master_rate_select == cfg_q[3])
      else $error("rate select");
   low_group_a: assert property (wa_q |-> ##3 extended_loss_window == cfg_q[1])
      else $error("lower group");
   retune_start_a: assert property (wa_q && hwdata[6:3] != cfg_q[6:3]
      |-> ##[1:4] synth_retuning) else $error("no retune");
   rx_squelch_a: assert property ((cfg_q[2] && &rx_signal_loss)[*6]
      |-> rx_positive_out == 0) else $error("not muted");
   code_route_a: assert property ((!cfg_q[7] && $stable(code_violation_in))[*6]
      |-> violation_event_output == code_violation_in) else $error("code route");
   ovf_route_a: assert property ((cfg_q[7] && $stable(counter_overflow_in))[*6]
      |-> violation_event_output == counter_overflow_in) else $error("ovf route");
   reset_clear_a: assert property (disable iff (1'b0) !reset_n |=> !synth_ref_select
      && !master_rate_select) else $error("reset value");
   cover property (wa_q);
   cover property (synth_retuning);
   cover property (cfg_q[2] && &rx_signal_loss);
endmodule
bind master_clock_select_config mcs_chk #(.CHANNELS(CHANNELS)) mcs_chk_inst (.*);
`default_nettype wire

// ### test/cfg_host.sv
// host model: ahb-lite master of the clock select block
// assumes hready is the slave's hreadyout
`timescale 1ns/1ps
`default_nettype none
module cfg_host
(
   // clock
   input  wire              clock,
   // ahb-lite master side
   output var logic         hsel,
   output var logic [11:0]  haddr,
   output var logic [1:0]   htrans,
   output var logic         hwrite,
   output var logic [2:0]   hsize,
   output var logic [31:0]  hwdata,
   input  wire              hready,
   input  wire      [31:0]  hrdata
);
   logic [7:0] cur;
   initial {cur, hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
   task automatic xfer(input logic w, logic [11:0] a, logic [31:0] d, output logic [31:0] q);
      @(posedge clock);
      {hsel, htrans, haddr, hwrite, hsize} <= {3'b110, a, w, 3'b010};
      do @(posedge clock); while (hready !== 1'b1);
      {hsel, htrans, hwdata} <= {3'b000, d};
      do @(posedge clock); while (hready !== 1'b1);
      q = hrdata;
      if (w && a == 12'h204) cur = d[7:0];
   endtask
   // one group per write, order picked by lf
   task automatic cfg_set(input logic [7:0] v, logic lf);
      logic [31:0] q;
      xfer(1'b1, 12'h204, {24'h0, lf ? {cur[7:3], v[2:0]} : {v[7:3], cur[2:0]}}, q);
      xfer(1'b1, 12'h204, {24'h0, v}, q);
   endtask
endmodule
`default_nettype wire

// ### test/master_clock_select_config_tb_top.sv
// self-checking bench for the clock select block
// assumes cfg_host on the bus and mcs_chk bound in
`timescale 1ns/1ps
`default_nettype none
module master_clock_select_config_tb_top;
   logic        clock = 1'b0;
   logic        reset_n, hsel, hwrite, hreadyout, hresp, irq, master_rate_select;
   logic        synth_retuning, extended_loss_window, board_test_tristate;
   logic [1:0]  htrans;
   logic [2:0]  hsize, synth_ref_select;
   logic [11:0] haddr;
   logic [31:0] hwdata, hrdata, q;
   logic [7:0]  rx_signal_loss, rx_pos_in, rx_neg_in, code_violation_in, counter_overflow_in;
   logic [7:0]  rx_positive_out, rx_negative_out, violation_event_output, v;
   int          fails = 0;
   int          cmp_count = 0;
   master_clock_select_config master_clock_select_config_inst (.*, .hready(hreadyout));
   cfg_host cfg_host_inst (.*, .hready(hreadyout));
   task automatic chk(string n, logic [31:0] s, e);
      cmp_count++;
      fails += int'(s !== e);
      if (s !== e) $display("mismatch %s exp %h got %h", n, e, s);
   endtask
   task automatic wrap_up;
      if (fails == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   function automatic logic [7:0] rx_exp(logic m, logic [7:0] d);
      return m ? d & ~rx_signal_loss : d;
   endfunction
   function automatic logic [7:0] viol_exp(logic s);
      return s ? counter_overflow_in : code_violation_in;
   endfunction
   initial forever #2 clock = ~clock;
   initial
   begin
      #20000;
      fails++;
      wrap_up;
   end
   initial
   begin
      reset_n = 1'b0;
      {rx_signal_loss, rx_pos_in, rx_neg_in, code_violation_in, counter_overflow_in} = '0;
      void'($urandom(32'h8a2d_c069));
      repeat (20) @(posedge clock);
      reset_n <= 1'b1;
      cfg_host_inst.xfer(1'b0, 12'h204, 32'h0, q);
      chk("cfg reset", q, 32'h0);
      for (int i = 0; i < 8; i++)
      begin
         v = {1'($urandom), 3'(i), 4'($urandom) | (i == 7 ? 4'h4 : 4'h0)};
         cfg_host_inst.cfg_set(v, i[0]);
         {rx_signal_loss, rx_pos_in, rx_neg_in, code_violation_in, counter_overflow_in} <=
            {i == 7 ? 8'hff : 8'($urandom), 32'($urandom)};
         repeat (9) @(posedge clock);
         @(negedge clock);
         chk("rx pos", rx_positive_out, rx_exp(v[2], rx_pos_in));
         chk("rx neg", rx_negative_out, rx_exp(v[2], rx_neg_in));
         chk("viol", violation_event_output, viol_exp(v[7]));
         chk("ref sel", synth_ref_select, v[6:4]);
         chk("rate", master_rate_select, v[3]);
         chk("test tri", board_test_tristate, v[0]);
         chk("resp", {hresp, hreadyout}, 32'h1);
         cfg_host_inst.xfer(1'b0, 12'h204, 32'h0, q);
         chk("cfg", q, {24'h0, v});
      end
      cfg_host_inst.xfer(1'b1, 12'h208, 32'h3, q);
      cfg_host_inst.xfer(1'b1, 12'h20c, 32'h2, q);
      cfg_host_inst.xfer(1'b1, 12'h204, {24'h0, ~v}, q);
      repeat (2) @(negedge clock);
      chk("retuning", synth_retuning, 32'h1);
      repeat (15) @(posedge clock);
      cfg_host_inst.xfer(1'b0, 12'h208, 32'h0, q);
      chk("status", q, 32'h3);
      chk("retune end", synth_retuning, 32'h0);
      @(negedge clock);
      chk("irq on", irq, 32'h1);
      cfg_host_inst.xfer(1'b1, 12'h20c, 32'h0, q);
      repeat (2) @(negedge clock);
      chk("irq masked", irq, 32'h0);
      cfg_host_inst.xfer(1'b1, 12'h208, 32'h3, q);
      cfg_host_inst.xfer(1'b0, 12'h208, 32'h0, q);
      chk("status clr", q, 32'h0);
      cfg_host_inst.cfg_set(8'h8d, 1'b0);
      repeat (3) @(negedge clock);
      chk("rate set", master_rate_select, 32'h1);
      @(posedge clock);
      reset_n <= 1'b0;
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      @(negedge clock);
      chk("rate reset", master_rate_select, 32'h0);
      cfg_host_inst.xfer(1'b0, 12'h204, 32'h0, q);
      chk("cfg reset 2", q, 32'h0);
      cfg_host_inst.xfer(1'b0, 12'h300, 32'h0, q);
      chk("unmapped", q, 32'h0);
      wrap_up;
   end
endmodule
`default_nettype wire
